/* File: src/clamp_map.svh */
// Register addresses, field positions, reset values and codes of the
// clamp timing generator. Included by the package users, no logic here.
`ifndef CLAMP_MAP_SVH
`define CLAMP_MAP_SVH

`define REG_START_DELAY 8'h19
`define REG_WINDOW_LEN 8'h1A
`define REG_CLAMP_SEL 8'h1B
`define REG_CLAMP_STATUS 8'h1C

`define START_DELAY_RST 8'h08
`define WINDOW_LEN_RST 8'h14
`define CLAMP_SEL_RST 3'h0
`define CLAMP_SEL_LSB 5

`define CLAMP_BLACK_CODE 8'h00
`define CLAMP_MID_CODE 8'h80

`endif

/* File: src/clamp_pkg.sv */
// Types used by the clamp timing generator; its offset servo uses none of them.
// Assumes clamp_map.svh for all numeric constants.
package clamp_pkg;

	typedef enum logic [1:0] {CL_IDLE, CL_DELAY, CL_ACTIVE} clamp_state_e;

	typedef enum logic [2:0] {
		I_IDLE, I_DEV, I_SUB, I_WR, I_RD
	} serial_state_e;

	typedef struct packed {
		logic [7:0] start_delay;
		logic [7:0] window_len;
		logic [2:0] mid_sel;
	} clamp_cfg_s;

endpackage : clamp_pkg

/* File: src/clamp_offset_servo.sv */
// Per-channel offset servo: steps the offset while the clamp window is
// open so the converter code settles on the target, then holds it.
// Assumes adc_code is the converter output sampled on sys_clk.
`include "clamp_map.svh"

module clamp_offset_servo #(
	parameter int OFF_W = 8
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clamp_active,
	input wire logic mid_sel,
	input wire logic [7:0] adc_code,
	output logic [OFF_W-1:0] offset
);

	localparam logic [OFF_W-1:0] OFF_MID = {1'b1, {(OFF_W-1){1'b0}}};
	localparam logic [OFF_W-1:0] OFF_MAX = {OFF_W{1'b1}};

	logic [7:0] target;
	logic [OFF_W-1:0] offset_r;

	if (OFF_W < 2) begin : g_chk
		$error("clamp_offset_servo: OFF_W must be at least 2");
	end

	assign target = mid_sel ? `CLAMP_MID_CODE : `CLAMP_BLACK_CODE;
	assign offset = offset_r;

	// Raising the offset raises the code; saturate instead of wrapping
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			offset_r <= OFF_MID;
		end else if (clamp_active) begin
			if (adc_code > target && offset_r != '0) begin
				offset_r <= offset_r - 1'b1;
			end else if (adc_code < target && offset_r != OFF_MAX) begin
				offset_r <= offset_r + 1'b1;
			end
		end
	end

	a_servo_down: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clamp_active && adc_code > target && offset_r != '0
		|=> offset_r == $past(offset_r) - 1'b1)
		else $error("offset did not step down above target");

	a_servo_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!clamp_active |=> $stable(offset_r))
		else $error("offset moved outside the clamp window");

	c_servo_step: cover property (@(posedge sys_clk) disable iff (!rst_b)
		clamp_active && adc_code < target ##1 $changed(offset_r));

endmodule : clamp_offset_servo

/* File: src/video_clamp_timing_generator.sv */
// Clamp timing generator with its 2-wire control port and three
// offset servos. Assumes sys_clk is the pixel clock and that hsync,
// scl_in and sda_in are already synchronous to it.
//
// Functional notes
// - Clamp starts placement periods after sync trailing edge.
// - Clamp lasts duration periods, then off until next line.
// - Placement and duration are eight-bit, 0 to 255.
// - During clamp, offset servoed so black gives target.
// - All settings written over the 2-wire port.
// - Each channel selects midscale or ground clamp.
`include "clamp_map.svh"

module video_clamp_timing_generator #(
	parameter logic [6:0] DEV_ADDR = 7'h4C,
	parameter int OFF_W = 8
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic hsync,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic [2:0][7:0] adc_code,
	output logic [2:0][OFF_W-1:0] offset,
	output logic [2:0] clamp_mid,
	output logic clamp_active
);

	clamp_pkg::clamp_cfg_s cfg_r;
	clamp_pkg::clamp_state_e cl_st_r;
	clamp_pkg::serial_state_e sp_st_r;
	logic [7:0] cnt_r;
	logic hsync_q;
	logic hs_trail;
	logic scl_q, sda_q;
	logic scl_rise, scl_fall, sp_start, sp_stop;
	logic [7:0] shreg_r;
	logic [7:0] sub_r;
	logic [3:0] bit_r;
	logic ack_r, rw_r, nack_r, drv_r;
	logic wr_stb;
	logic [7:0] rd_byte;

	// Sync trailing edge: hsync is active high
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			hsync_q <= 1'b0;
		end else begin
			hsync_q <= hsync;
		end
	end

	assign hs_trail = hsync_q & ~hsync;

	// One down-counter serves both placement and duration phases
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cl_st_r <= clamp_pkg::CL_IDLE;
			cnt_r <= 8'h00;
		end else if (hs_trail) begin
			if (cfg_r.start_delay != 8'h00) begin
				cl_st_r <= clamp_pkg::CL_DELAY;
				cnt_r <= cfg_r.start_delay;
			end else if (cfg_r.window_len != 8'h00) begin
				cl_st_r <= clamp_pkg::CL_ACTIVE;
				cnt_r <= cfg_r.window_len;
			end else begin
				cl_st_r <= clamp_pkg::CL_IDLE;
			end
		end else begin
			unique case (cl_st_r)
				clamp_pkg::CL_IDLE: begin
					cnt_r <= 8'h00;
				end
				clamp_pkg::CL_DELAY: begin
					if (cnt_r != 8'h01) begin
						cnt_r <= cnt_r - 8'h01;
					end else if (cfg_r.window_len != 8'h00) begin
						cl_st_r <= clamp_pkg::CL_ACTIVE;
						cnt_r <= cfg_r.window_len;
					end else begin
						cl_st_r <= clamp_pkg::CL_IDLE;
					end
				end
				clamp_pkg::CL_ACTIVE: begin
					if (cnt_r != 8'h01) begin
						cnt_r <= cnt_r - 8'h01;
					end else begin
						cl_st_r <= clamp_pkg::CL_IDLE;
					end
				end
			endcase
		end
	end

	assign clamp_active = (cl_st_r == clamp_pkg::CL_ACTIVE);
	assign clamp_mid = cfg_r.mid_sel;

	for (genvar ch = 0; ch < 3; ch++) begin : g_chan
		clamp_offset_servo #(
			.OFF_W(OFF_W)
		) u_servo (
			.sys_clk(sys_clk),
			.rst_b(rst_b),
			.clamp_active(clamp_active),
			.mid_sel(cfg_r.mid_sel[ch]),
			.adc_code(adc_code[ch]),
			.offset(offset[ch])
		);
	end

	// 2-wire port: line events from one-cycle-old samples
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	assign scl_rise = scl_in & ~scl_q;
	assign scl_fall = ~scl_in & scl_q;
	assign sp_start = scl_in & scl_q & sda_q & ~sda_in;
	assign sp_stop = scl_in & scl_q & ~sda_q & sda_in;
	assign wr_stb = scl_fall & ~ack_r & (bit_r == 4'h8)
		& (sp_st_r == clamp_pkg::I_WR);

	always_comb begin
		unique case (sub_r)
			`REG_START_DELAY: rd_byte = cfg_r.start_delay;
			`REG_WINDOW_LEN: rd_byte = cfg_r.window_len;
			`REG_CLAMP_SEL: rd_byte = {cfg_r.mid_sel, 5'h00};
			`REG_CLAMP_STATUS: rd_byte = {6'h00,
				cl_st_r == clamp_pkg::CL_DELAY, clamp_active};
			default: rd_byte = 8'h00;
		endcase
	end

	// Byte framing; data changes only while scl is low
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sp_st_r <= clamp_pkg::I_IDLE;
			shreg_r <= 8'h00;
			sub_r <= 8'h00;
			bit_r <= 4'h0;
			ack_r <= 1'b0;
			rw_r <= 1'b0;
			nack_r <= 1'b0;
			drv_r <= 1'b0;
		end else if (sp_start) begin
			sp_st_r <= clamp_pkg::I_DEV;
			bit_r <= 4'h0;
			ack_r <= 1'b0;
			drv_r <= 1'b0;
		end else if (sp_stop) begin
			sp_st_r <= clamp_pkg::I_IDLE;
			drv_r <= 1'b0;
		end else if (sp_st_r == clamp_pkg::I_IDLE) begin
			drv_r <= 1'b0;
		end else if (scl_rise) begin
			if (ack_r) begin
				nack_r <= sda_in;
			end else begin
				bit_r <= bit_r + 4'h1;
				if (sp_st_r != clamp_pkg::I_RD) begin
					shreg_r <= {shreg_r[6:0], sda_in};
				end
			end
		end else if (scl_fall && !ack_r && bit_r == 4'h8) begin
			ack_r <= 1'b1;
			bit_r <= 4'h0;
			drv_r <= 1'b1;
			unique case (sp_st_r)
				clamp_pkg::I_DEV: begin
					rw_r <= shreg_r[0];
					if (shreg_r[7:1] != DEV_ADDR) begin
						sp_st_r <= clamp_pkg::I_IDLE;
						drv_r <= 1'b0;
					end
				end
				clamp_pkg::I_SUB: sub_r <= shreg_r;
				clamp_pkg::I_WR: sub_r <= sub_r + 8'h01;
				clamp_pkg::I_RD: begin
					sub_r <= sub_r + 8'h01;
					drv_r <= 1'b0;
				end
				default: drv_r <= 1'b0;
			endcase
		end else if (scl_fall && ack_r) begin
			ack_r <= 1'b0;
			drv_r <= 1'b0;
			if ((sp_st_r == clamp_pkg::I_DEV && rw_r)
				|| (sp_st_r == clamp_pkg::I_RD && !nack_r)) begin
				sp_st_r <= clamp_pkg::I_RD;
				drv_r <= ~rd_byte[7];
				shreg_r <= {rd_byte[6:0], 1'b0};
			end else if (sp_st_r == clamp_pkg::I_RD) begin
				sp_st_r <= clamp_pkg::I_IDLE;
			end else if (sp_st_r == clamp_pkg::I_DEV) begin
				sp_st_r <= clamp_pkg::I_SUB;
			end else begin
				sp_st_r <= clamp_pkg::I_WR;
			end
		end else if (scl_fall && sp_st_r == clamp_pkg::I_RD) begin
			drv_r <= ~shreg_r[7];
			shreg_r <= {shreg_r[6:0], 1'b0};
		end
	end

	// Open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe_n = ~drv_r;

	// Settings apply from the next pixel; a placement or duration change
	// mid-line affects only counts not yet loaded
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cfg_r.start_delay <= `START_DELAY_RST;
			cfg_r.window_len <= `WINDOW_LEN_RST;
			cfg_r.mid_sel <= `CLAMP_SEL_RST;
		end else if (wr_stb) begin
			unique case (sub_r)
				`REG_START_DELAY: cfg_r.start_delay <= shreg_r;
				`REG_WINDOW_LEN: cfg_r.window_len <= shreg_r;
				`REG_CLAMP_SEL: cfg_r.mid_sel <=
					shreg_r[`CLAMP_SEL_LSB +: 3];
				default: ;
			endcase
		end
	end

	a_place_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
		hs_trail && cfg_r.start_delay != 8'h00
		|=> cl_st_r == clamp_pkg::CL_DELAY
			&& cnt_r == $past(cfg_r.start_delay))
		else $error("placement count not loaded on sync edge");

	a_place_end: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cl_st_r == clamp_pkg::CL_DELAY && cnt_r == 8'h01 && !hs_trail
		&& cfg_r.window_len != 8'h00 |=> clamp_active)
		else $error("clamp did not open after placement");

	a_window_len: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(clamp_active) && !$past(hs_trail)
		|-> cnt_r == $past(cfg_r.window_len))
		else $error("clamp window length not loaded");

	a_window_end: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clamp_active && cnt_r == 8'h01 && !hs_trail
		|=> !clamp_active)
		else $error("clamp window overran its length");

	a_early_cut: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clamp_active && hs_trail && cfg_r.start_delay != 8'h00
		|=> !clamp_active)
		else $error("open clamp not cut by new sync edge");

	a_reg_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_stb && sub_r == `REG_START_DELAY
		|=> cfg_r.start_delay == $past(shreg_r))
		else $error("placement write not applied");

	a_mid_select: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_stb && sub_r == `REG_CLAMP_SEL
		|=> clamp_mid == $past(shreg_r[7:5]))
		else $error("clamp select bits not applied");

	c_clamp_open: cover property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(clamp_active));
	c_clamp_cut: cover property (@(posedge sys_clk) disable iff (!rst_b)
		clamp_active && hs_trail);
	c_reg_read: cover property (@(posedge sys_clk) disable iff (!rst_b)
		sp_st_r == clamp_pkg::I_RD && !sda_oe_n);

endmodule : video_clamp_timing_generator

/* File: testbench/video_source.sv */
// Model of the analog video source: horizontal sync and converted codes.
// Assumes the bench calls send_sync and the design feeds back offset.
module video_source #(
	parameter logic [23:0] LEVELS = 24'h30_5050
) (
	input wire logic sys_clk,
	input wire logic [2:0][7:0] offset,
	output logic hsync,
	output logic [2:0][7:0] adc_code
);
	timeunit 1ns;
	timeprecision 1ns;

	initial hsync = 1'b0;

	// Higher offset gives a higher code; the converter clips at both ends
	always_comb begin
		for (int c = 0; c < 3; c++) begin
			int v;
			v = int'(LEVELS[c*8 +: 8]) + int'(offset[c]) - 32'h0000_0080;
			adc_code[c] = (v < 0) ? 8'h00 : (v > 255) ? 8'hFF : v[7:0];
		end
	end

	// Sync pulse of w cycles; the last edge of the call lowers it
	task automatic send_sync(input int w);
		@(posedge sys_clk) hsync <= 1'b1;
		repeat (w) @(posedge sys_clk);
		hsync <= 1'b0;
	endtask : send_sync

endmodule : video_source

/* File: testbench/testbench.sv */
// Self-checking bench for the clamp timing generator.
// Assumes the design sources and the video source model are compiled.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	// Device address value is arbitrary
	localparam logic [6:0] DEV = 7'h4C;
	localparam logic [7:0] DEV_W = {DEV, 1'b0};

	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic scl = 1'b1;
	logic sda_m = 1'b1;
	logic hsync, sda_out, sda_oe_n, clamp_active;
	logic [2:0][7:0] adc_code, offset;
	logic [2:0] clamp_mid;
	// Open drain with pull-up: low when either side pulls
	wire logic sda_in = sda_m & (sda_oe_n | sda_out);
	int miscompares = 0;
	int cmp_count = 0;

	always #25 sys_clk = ~sys_clk;

	video_clamp_timing_generator #(.DEV_ADDR(DEV), .OFF_W(8))
	video_clamp_timing_generator_i (
		.sys_clk(sys_clk), .rst_b(rst_b), .hsync(hsync),
		.scl_in(scl), .sda_in(sda_in), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .adc_code(adc_code), .offset(offset),
		.clamp_mid(clamp_mid), .clamp_active(clamp_active)
	);

	video_source video_source_i (
		.sys_clk(sys_clk), .offset(offset), .hsync(hsync),
		.adc_code(adc_code)
	);

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick

	task automatic check(input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	// One bit with scl phases of four cycles; sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'b0;
		tick(2);
		sda_m <= b;
		tick(2);
		scl <= 1'b1;
		tick(2);
		r = sda_in;
		tick(2);
	endtask : bit_io

	// s=1 gives a start (or repeated start), s=0 a stop
	task automatic frame(input logic s);
		scl <= 1'b0;
		tick(2);
		sda_m <= s;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sda_m <= ~s;
		tick(4);
	endtask : frame

	task automatic xfer(input logic [7:0] d, input logic last,
		output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(last, a);
	endtask : xfer

	task automatic wr(input logic [7:0] dev, sub, d0, d1,
		input logic nack);
		logic [3:0][7:0] b;
		logic [7:0] r;
		logic a;
		b = {dev, sub, d0, d1};
		frame(1'b1);
		for (int k = 3; k >= 0; k--) begin
			xfer(b[k], 1'b1, r, a);
			check(a, nack);
		end
		frame(1'b0);
	endtask : wr

	// nxt[8] set: ACK the first byte, read one more and expect nxt[7:0]
	task automatic rd(input logic [7:0] sub, output logic [7:0] d,
		input logic [8:0] nxt);
		logic [7:0] r;
		logic a;
		frame(1'b1);
		xfer(DEV_W, 1'b1, r, a);
		xfer(sub, 1'b1, r, a);
		frame(1'b1);
		xfer({DEV, 1'b1}, 1'b1, r, a);
		xfer(8'hFF, ~nxt[8], d, a);
		if (nxt[8]) begin
			xfer(8'hFF, 1'b1, r, a);
			check(r, nxt[7:0]);
		end
		frame(1'b0);
	endtask : rd

	// One line: open delay and window length after the sync trailing edge
	task automatic line_chk(input logic [7:0] p, d);
		int n;
		int len;
		n = 0;
		len = 0;
		video_source_i.send_sync(3);
		do begin
			tick(1);
			#1;
			n++;
		end while (clamp_active !== 1'b1 && n < 300);
		if (d == 8'h00) begin
			check(clamp_active, 1'b0);
		end else begin
			check(n, p + 32'h0000_0001);
			while (clamp_active === 1'b1 && len < 300) begin
				tick(1);
				#1;
				len++;
			end
			check(len, d);
		end
		if (d != 8'h00 && (n == 300 || len == 300)) finish_test();
		tick(1);
	endtask : line_chk

	initial begin
		logic [7:0] v;
		logic [4:0][7:0] rst_v;
		logic [3:0][7:0] tp;
		logic [3:0][7:0] td;
		logic [1:0][7:0] sel;
		rst_v = {8'h00, 8'h00, 8'h00, 8'h14, 8'h08};
		tp = {8'hFF, 8'h05, 8'h00, 8'h26};
		td = {8'h02, 8'h00, 8'h01, 8'h14};
		sel = {8'h40, 8'hA0};
		tick(5);
		rst_b <= 1'b1;
		tick(1);
		check({offset, sda_oe_n, clamp_active}, {24'h80_8080, 2'h2});
		// Reset values, status and one unmapped place
		for (int k = 0; k < 5; k++) begin
			rd(8'h19 + k[7:0], v, 9'h000);
			check(v, rst_v[k]);
		end
		line_chk(8'h08, 8'h14);
		wr({DEV ^ 7'h01, 1'b0}, 8'h19, 8'h00, 8'h00, 1'b1);
		rd(8'h19, v, 9'h000);
		check(v, 8'h08);
		// Auto-increment write of placement and duration, boundaries
		for (int k = 0; k < 4; k++) begin
			wr(DEV_W, 8'h19, tp[k], td[k], 1'b0);
			rd(8'h19, v, {1'b1, td[k]});
			check(v, tp[k]);
			rd(8'h1A, v, 9'h000);
			check(v, td[k]);
			line_chk(tp[k], td[k]);
		end
		// Status byte is taken about 240 cycles into the read, well
		// inside the 255-cycle placement phase
		video_source_i.send_sync(3);
		rd(8'h1C, v, 9'h000);
		check(v, 8'h02);
		// A second edge inside the window must restart the timing
		wr(DEV_W, 8'h19, 8'h02, 8'h14, 1'b0);
		video_source_i.send_sync(3);
		tick(4);
		#1;
		check(clamp_active, 1'b1);
		line_chk(8'h02, 8'h14);
		// Servo settles each channel on its own target within one line
		wr(DEV_W, 8'h19, 8'h00, 8'hFF, 1'b0);
		for (int k = 0; k < 2; k++) begin
			wr(DEV_W, 8'h1B, sel[k], 8'h00, 1'b0);
			check(clamp_mid, sel[k][7:5]);
			line_chk(8'h00, 8'hFF);
			for (int c = 0; c < 3; c++) begin
				check(adc_code[c], sel[k][5+c] ? 8'h80 : 8'h00);
			end
		end
		finish_test();
	end

endmodule : testbench
